// ### core/pxb_crossbar.v
// Purpose: Priority crossbar routing peripherals onto an eight-pin port
// Assumes: AHB-Lite slave, single word transfers, no wait states
// Notes:   Routing map is registered one cycle after any setting changes
//
// Notes on behaviour
// - Routable functions ranked in fixed priority, serial port first, pins given in order.
// - Each enabled function takes the lowest free, unskipped pin.
// - A pin already given away is passed over for the next function.
// - Skip mask bit set marks that pin as taken.
// - Serial transmit fixed on pin 4, serial receive fixed on pin 5.
// - Two-wire bus claims two pins, data then clock.
// - Leftover pins stay general purpose after assigned functions.
// - Router enable off turns all pin drivers off; each pin keeps its digital or analog input mode.
// - Pull-ups on open-drain pins unless pull-up disable is set.
// - Pull-up off on an open-drain pin driving low.
// - Two-wire bus pins are always open-drain.
// - Analog pins have pull-up, driver and receiver off.
// - Input mode 1 digital, 0 analog; reset gives digital.
// - Counter module field routes zero to three module pins.
// - Route register low six bits enable the listed functions.
// - Third register bits route timer 1, timer 0, counter clock input.
// - Unused bits read zero and ignore writes.
// - Port read returns actual levels of digital-mode pins whatever the routing.
// - Output mode 1 push-pull, 0 open-drain, ignored for analog pins.
// - Port write latches output values; analog pins read 1.
`timescale 1ns/100ps
`default_nettype none
`include "pxb_defines.vh"

module pxb_crossbar (
  // Clock and reset
  input  wire        hclk,
  input  wire        hresetn,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output reg  [31:0] hrdata,
  // Port pins
  input  wire [7:0]  pin_in,
  output wire [7:0]  pin_out,
  output wire [7:0]  pin_oe_n,
  output wire [7:0]  pin_pullup_en,
  output wire [7:0]  pin_dig_in_en,
  // Peripheral outputs
  input  wire        serial_tx,
  input  wire        twb_sda_out,
  input  wire        twb_scl_out,
  input  wire        comparator_output,
  input  wire        comparator_async_out,
  input  wire        sysclk_inv,
  input  wire [2:0]  counter_module_out,
  // Peripheral inputs
  output wire        serial_rx,
  output wire        twb_sda_in,
  output wire        twb_scl_in,
  output wire [2:0]  counter_module_in,
  output wire        counter_external_clock_in,
  output wire        timer0_in,
  output wire        timer1_in
);

  // ****************************************
  // Registers
  // ****************************************
  reg [7:0]  port_latch_r;
  reg [7:0]  pin_output_mode_r;
  reg [6:0]  pin_skip_bits_r;
  reg [7:0]  route_r;
  reg [7:0]  pin_input_mode_r;
  reg [7:0]  xbar_r;
  reg [7:0]  pin_s1_r;
  reg [7:0]  pin_s2_r;
  reg        dph_wr_r;
  reg [9:0]  dph_idx_r;
  reg [31:0] owner_r;
  reg [7:0]  owned_r;

  wire       router_enable;
  wire       pullup_disable;
  wire [1:0] counter_module_route_field;
  wire       addr_ok;
  wire [7:0] pin_level;

  assign router_enable              = xbar_r[`PXB_XBAR_EN];
  assign pullup_disable             = xbar_r[`PXB_XBAR_PUD];
  assign counter_module_route_field = route_r[`PXB_ROUTE_CEX_HI:`PXB_ROUTE_CEX_LO];

  // ****************************************
  // AHB-Lite slave
  // ****************************************
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign addr_ok   = hsel & hready & htrans[1];

  // Pin synchroniser
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_s1_r <= 8'h00;
      pin_s2_r <= 8'h00;
    end else begin
      pin_s1_r <= pin_in;
      pin_s2_r <= pin_s1_r;
    end
  end

  // Receiver off reads 1 on analog pins
  assign pin_level = pin_s2_r | ~pin_input_mode_r;

  function [7:0] read_reg;
    input [9:0] idx;
    begin
      case (idx)
        `PXB_IDX_PORT:     read_reg = pin_level;
        `PXB_IDX_OUT_MODE: read_reg = pin_output_mode_r;
        `PXB_IDX_SKIP:     read_reg = {1'b0, pin_skip_bits_r};
        `PXB_IDX_ROUTE:    read_reg = route_r;
        `PXB_IDX_IN_MODE:  read_reg = pin_input_mode_r;
        `PXB_IDX_XBAR:     read_reg = xbar_r & `PXB_XBAR_MASK;
        default:           read_reg = 8'h00;
      endcase
    end
  endfunction

  // Address phase capture and read data
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_wr_r  <= 1'b0;
      dph_idx_r <= 10'h000;
      hrdata    <= 32'h0000_0000;
    end else if (hready) begin
      dph_wr_r  <= addr_ok & hwrite;
      dph_idx_r <= haddr[11:2];
      if (addr_ok && !hwrite) begin
        hrdata <= {24'h00_0000, read_reg(haddr[11:2])};
      end
    end
  end

  // Data phase writes
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_latch_r      <= `PXB_RST_PORT;
      pin_output_mode_r <= `PXB_RST_OUT_MODE;
      pin_skip_bits_r   <= `PXB_RST_SKIP;
      route_r           <= `PXB_RST_ROUTE;
      pin_input_mode_r  <= `PXB_RST_IN_MODE;
      xbar_r            <= `PXB_RST_XBAR;
    end else if (dph_wr_r) begin
      case (dph_idx_r)
        `PXB_IDX_PORT:     port_latch_r      <= hwdata[7:0];
        `PXB_IDX_OUT_MODE: pin_output_mode_r <= hwdata[7:0];
        `PXB_IDX_SKIP:     pin_skip_bits_r   <= hwdata[6:0];
        `PXB_IDX_ROUTE:    route_r           <= hwdata[7:0];
        `PXB_IDX_IN_MODE:  pin_input_mode_r  <= hwdata[7:0];
        `PXB_IDX_XBAR:     xbar_r            <= hwdata[7:0] & `PXB_XBAR_MASK;
        default:           xbar_r            <= xbar_r;
      endcase
    end
  end

  // ****************************************
  // Priority assignment
  // ****************************************
  wire [`PXB_NFUNC-1:0] func_en;
  wire [7:0]            taken;
  wire [31:0]           owner_nxt;
  wire [7:0]            owned_nxt;
  wire                  tx_en;
  wire                  rx_en;

  assign tx_en = route_r[`PXB_ROUTE_TX];
  assign rx_en = route_r[`PXB_ROUTE_RX];

  // Priority order: bus data, bus clock, comparator, async comparator,
  // inverted clock, counter modules, counter clock, timer 0, timer 1
  assign func_en = {
    xbar_r[`PXB_XBAR_T1],
    xbar_r[`PXB_XBAR_T0],
    xbar_r[`PXB_XBAR_ECI],
    counter_module_route_field == 2'b11,
    counter_module_route_field[1],
    counter_module_route_field != 2'b00,
    route_r[`PXB_ROUTE_SYSCK],
    route_r[`PXB_ROUTE_CMPA],
    route_r[`PXB_ROUTE_CMP],
    route_r[`PXB_ROUTE_TWB],
    route_r[`PXB_ROUTE_TWB]
  };

  // Fixed serial pins are reserved before the priority walk
  assign taken = {1'b0, pin_skip_bits_r}
               | ({7'h00, tx_en} << `PXB_TX_PIN)
               | ({7'h00, rx_en} << `PXB_RX_PIN);

  pxb_assign #(
    .NFUNC (`PXB_NFUNC),
    .NPIN  (8)
  ) u_assign (
    .func_en    (func_en),
    .taken      (taken),
    .owner_flat (owner_nxt),
    .owned      (owned_nxt)
  );

  // Map recomputed every cycle from current settings
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      owner_r <= 32'h0000_0000;
      owned_r <= 8'h00;
    end else begin
      owner_r <= owner_nxt;
      owned_r <= owned_nxt;
      if (tx_en) begin
        owner_r[`PXB_TX_PIN*4+:4] <= `PXB_F_TX;
        owned_r[`PXB_TX_PIN]      <= 1'b1;
      end
      if (rx_en) begin
        owner_r[`PXB_RX_PIN*4+:4] <= `PXB_F_RX;
        owned_r[`PXB_RX_PIN]      <= 1'b1;
      end
    end
  end

  // ****************************************
  // Function decode
  // ****************************************
  function fn_is_out;
    input [3:0] code;
    begin
      case (code)
        `PXB_F_ECI, `PXB_F_T0, `PXB_F_T1, `PXB_F_RX: fn_is_out = 1'b0;
        default:                                     fn_is_out = 1'b1;
      endcase
    end
  endfunction

  // Routed output value, indexed by function code
  function fn_val;
    input [3:0]  code;
    input [15:0] vec;
    begin
      fn_val = vec[code];
    end
  endfunction

  // Level of the pin owned by a function, idle high when unrouted
  function pick_in;
    input [3:0]  code;
    input [7:0]  own_map;
    input [31:0] owner;
    input [7:0]  lvl;
    integer      p;
    begin
      pick_in = 1'b1;
      for (p = 0; p < 8; p = p + 1) begin
        if (own_map[p] && owner[p*4+:4] == code) begin
          pick_in = lvl[p];
        end
      end
    end
  endfunction

  // ****************************************
  // Live routing
  // ****************************************
  // Sources reach the functions as arguments, so every change
  // re-evaluates the assignments that call them
  wire [15:0] fn_out_vec;
  wire [7:0]  live_own;

  assign live_own   = owned_r & {8{router_enable}};
  assign fn_out_vec = {
    4'hF,                   // Receive and unused codes
    serial_tx,
    1'b1,                   // Timer 1 input
    1'b1,                   // Timer 0 input
    1'b1,                   // Counter clock input
    counter_module_out,
    sysclk_inv,
    comparator_async_out,
    comparator_output,
    twb_scl_out,
    twb_sda_out
  };

  // ****************************************
  // Pin drive
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_pin
      wire [3:0] own;
      wire       twb_pin;
      wire       od;
      wire       val;
      wire       drives;

      assign own     = owner_r[g*4+:4];
      assign twb_pin = owned_r[g] & (own == `PXB_F_SDA | own == `PXB_F_SCL);
      assign od      = ~pin_output_mode_r[g] | twb_pin;
      assign val     = owned_r[g] ? fn_val(own, fn_out_vec) : port_latch_r[g];
      assign drives  = router_enable
                     & pin_input_mode_r[g]
                     & (owned_r[g] ? fn_is_out(own) : 1'b1)
                     & (od ? ~val : 1'b1);
      assign pin_out[g]       = val;
      assign pin_oe_n[g]      = ~drives;
      assign pin_pullup_en[g] = pin_input_mode_r[g] & ~pullup_disable & od
                              & ~(drives & ~val);
      assign pin_dig_in_en[g] = pin_input_mode_r[g];
    end
  endgenerate

  // ****************************************
  // Peripheral inputs
  // ****************************************
  // Synchronised level of the owning pin
  assign serial_rx                 = pick_in(`PXB_F_RX, live_own, owner_r, pin_level);
  assign twb_sda_in                = pick_in(`PXB_F_SDA, live_own, owner_r, pin_level);
  assign twb_scl_in                = pick_in(`PXB_F_SCL, live_own, owner_r, pin_level);
  assign counter_module_in[0]      = pick_in(`PXB_F_COUNTER_MODULE0_PIN, live_own, owner_r, pin_level);
  assign counter_module_in[1]      = pick_in(`PXB_F_CEX1, live_own, owner_r, pin_level);
  assign counter_module_in[2]      = pick_in(`PXB_F_CEX2, live_own, owner_r, pin_level);
  assign counter_external_clock_in = pick_in(`PXB_F_ECI, live_own, owner_r, pin_level);
  assign timer0_in                 = pick_in(`PXB_F_T0, live_own, owner_r, pin_level);
  assign timer1_in                 = pick_in(`PXB_F_T1, live_own, owner_r, pin_level);

endmodule // pxb_crossbar

`default_nettype wire

// ### core/pxb_defines.vh
// Purpose: Constants for the priority crossbar port mux
// Assumes: Register index times four gives the AHB byte address
// Notes:   Definitions only
`ifndef PXB_DEFINES_VH
`define PXB_DEFINES_VH

// ****************************************
// Register indexes (byte address = 4 x index)
// ****************************************
`define PXB_IDX_PORT      10'h080
`define PXB_IDX_OUT_MODE  10'h0A4
`define PXB_IDX_SKIP      10'h0E1
`define PXB_IDX_ROUTE     10'h0E2
`define PXB_IDX_IN_MODE   10'h0F1
`define PXB_IDX_XBAR      10'h0F3

// ****************************************
// Reset values
// ****************************************
`define PXB_RST_PORT      8'hFF
`define PXB_RST_OUT_MODE  8'h00
`define PXB_RST_SKIP      7'h00
`define PXB_RST_ROUTE     8'h00
`define PXB_RST_IN_MODE   8'hFF
`define PXB_RST_XBAR      8'h00

// ****************************************
// Field positions
// ****************************************
`define PXB_ROUTE_CEX_HI  7
`define PXB_ROUTE_CEX_LO  6
`define PXB_ROUTE_CMPA    5
`define PXB_ROUTE_CMP     4
`define PXB_ROUTE_SYSCK   3
`define PXB_ROUTE_TWB     2
`define PXB_ROUTE_RX      1
`define PXB_ROUTE_TX      0
`define PXB_XBAR_PUD      7
`define PXB_XBAR_EN       6
`define PXB_XBAR_T1       2
`define PXB_XBAR_T0       1
`define PXB_XBAR_ECI      0
`define PXB_XBAR_MASK     8'hC7

// ****************************************
// Fixed serial pins and function codes
// ****************************************
`define PXB_TX_PIN        4
`define PXB_RX_PIN        5
`define PXB_NFUNC         11
`define PXB_F_SDA         4'h0
`define PXB_F_SCL         4'h1
`define PXB_F_CMP         4'h2
`define PXB_F_CMPA        4'h3
`define PXB_F_SYSCK       4'h4
`define PXB_F_COUNTER_MODULE0_PIN        4'h5
`define PXB_F_CEX1        4'h6
`define PXB_F_CEX2        4'h7
`define PXB_F_ECI         4'h8
`define PXB_F_T0          4'h9
`define PXB_F_T1          4'hA
`define PXB_F_TX          4'hB
`define PXB_F_RX          4'hC

`endif

// ### core/pxb_assign.v
// Purpose: Priority pin assignment for the crossbar
// Assumes: Function bit 0 has the highest priority
// Notes:   Purely combinational
`timescale 1ns/100ps
`default_nettype none

module pxb_assign #(
  parameter NFUNC = 11,
  parameter NPIN  = 8
) (
  // Requests
  input  wire [NFUNC-1:0]  func_en,
  input  wire [NPIN-1:0]   taken,
  // Result
  output reg  [NPIN*4-1:0] owner_flat,
  output reg  [NPIN-1:0]   owned
);

  // ****************************************
  // Lowest free pin per function
  // ****************************************
  integer    f;
  integer    p;
  reg [NPIN-1:0] used;
  reg        found;

  always @* begin
    used       = taken;
    owned      = {NPIN{1'b0}};
    owner_flat = {(NPIN*4){1'b0}};
    found      = 1'b0;
    for (f = 0; f < NFUNC; f = f + 1) begin
      found = 1'b0;
      if (func_en[f]) begin
        for (p = 0; p < NPIN; p = p + 1) begin
          if (!found && !used[p]) begin
            used[p]           = 1'b1;
            owned[p]          = 1'b1;
            owner_flat[p*4+:4] = f[3:0];
            found             = 1'b1;
          end
        end
      end
    end
  end

endmodule // pxb_assign

`default_nettype wire

// ### bench/pxb_crossbar_properties.sv
// Purpose: Port-level checks for the crossbar
// Assumes: Sees only the top-level ports
// Notes:   Bound into every crossbar instance
`timescale 1ns/100ps
`default_nettype none
`include "pxb_defines.vh"

module pxb_props (
  // Clock, reset and bus
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  // Pins
  input wire logic [7:0]  pin_oe_n,
  input wire logic [7:0]  pin_pullup_en,
  input wire logic [7:0]  pin_dig_in_en
);
  // ****************************************
  // Shadow of the enable register
  // ****************************************
  logic wph_r;
  logic en_r;
  logic pud_r;
  logic rd_ph;
  assign rd_ph = hsel && hready && htrans[1] && !hwrite;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wph_r <= 1'b0;
      en_r  <= 1'b0;
      pud_r <= 1'b0;
    end else begin
      wph_r <= hsel && hready && htrans[1] && hwrite && haddr[11:2] == `PXB_IDX_XBAR;
      if (wph_r) begin
        en_r  <= hwdata[`PXB_XBAR_EN];
        pud_r <= hwdata[`PXB_XBAR_PUD];
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  off_no_drive_a: assert property (
    !en_r && $past(!en_r) |-> pin_oe_n == 8'hFF) else $error("pin driven while router off");
  analog_quiet_a: assert property (
    (~pin_dig_in_en & (~pin_oe_n | pin_pullup_en)) == 8'h00) else $error("analog pin active");
  pullup_drive_a: assert property (
    (pin_pullup_en & ~pin_oe_n) == 8'h00) else $error("pull-up on a driven pin");
  reset_digital_a: assert property (
    !$past(hresetn) |-> pin_dig_in_en == 8'hFF) else $error("pin not digital after reset");
  skip_top_a: assert property (
    rd_ph && haddr[11:2] == `PXB_IDX_SKIP |=> hrdata[31:7] == 25'h0) else $error("skip bit 7 set");
  xbar_unused_a: assert property (
    rd_ph && haddr[11:2] == `PXB_IDX_XBAR |=> hrdata[31:8] == 24'h0 && hrdata[5:3] == 3'h0)
    else $error("unused enable bits set");
  pullup_off_a: assert property (
    pud_r && $past(pud_r) |-> pin_pullup_en == 8'h00) else $error("pull-up while disabled");
  analog_reads_a: assert property (
    rd_ph && haddr[11:2] == `PXB_IDX_PORT |=> (~$past(pin_dig_in_en) & ~hrdata[7:0]) == 8'h00)
    else $error("analog pin read as 0");

  cover property (en_r && pin_oe_n != 8'hFF);
  cover property (rd_ph && haddr[11:2] == `PXB_IDX_SKIP);
  cover property (pud_r && pin_dig_in_en != 8'hFF);
endmodule // pxb_props

bind pxb_crossbar pxb_props u_props (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .pin_oe_n(pin_oe_n), .pin_pullup_en(pin_pullup_en), .pin_dig_in_en(pin_dig_in_en)
);
`default_nettype wire

// ### bench/pxb_board.sv
// Purpose: Board wiring on the eight port pins
// Assumes: Weak pull-down on the board where nothing else acts
// Notes:   Device driver wins over the test driver
`timescale 1ns/100ps
`default_nettype none

module pxb_board (
  // Device side
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe_n,
  input  wire logic [7:0] pin_pullup_en,
  // Test drive
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_val,
  // Wire level
  output var  logic [7:0] pin_level
);
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!pin_oe_n[i])
        pin_level[i] = pin_out[i];
      else if (ext_en[i])
        pin_level[i] = ext_val[i];
      else
        pin_level[i] = pin_pullup_en[i];
    end
  end
endmodule // pxb_board
`default_nettype wire

// ### bench/priority_crossbar_port_mux_tb.sv
// Purpose: Self-checking bench for the crossbar
// Assumes: Zero-wait AHB slave, two-stage pin synchroniser
// Notes:   One task per scenario
`timescale 1ns/100ps
`default_nettype none
`include "pxb_defines.vh"

module priority_crossbar_port_mux_tb;
  logic        hclk, hresetn, hsel, hwrite;
  logic [31:0] haddr, hwdata, rdq;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  ext_en, ext_val;
  logic        tx_o, sda_o, scl_o, cmp_o, cmpa_o, sck_o;
  logic [2:0]  cm_o;
  wire  [31:0] hrdata;
  wire         hreadyout, hresp, rx_i, sda_i, scl_i, eci_i, t0_i, t1_i;
  wire  [2:0]  cm_i;
  wire  [7:0]  pin_level, pin_out, pin_oe_n, pin_pullup_en, pin_dig_in_en;
  int          bad_count, checks_done;

  pxb_crossbar dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pin_in(pin_level),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_pullup_en(pin_pullup_en),
    .pin_dig_in_en(pin_dig_in_en), .serial_tx(tx_o), .twb_sda_out(sda_o),
    .twb_scl_out(scl_o), .comparator_output(cmp_o), .comparator_async_out(cmpa_o),
    .sysclk_inv(sck_o), .counter_module_out(cm_o), .serial_rx(rx_i), .twb_sda_in(sda_i),
    .twb_scl_in(scl_i), .counter_module_in(cm_i), .counter_external_clock_in(eci_i),
    .timer0_in(t0_i), .timer1_in(t1_i));
  pxb_board u_board (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_pullup_en(pin_pullup_en),
    .ext_en(ext_en), .ext_val(ext_val), .pin_level(pin_level));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic ahb(input logic w, input logic [9:0] idx, input logic [31:0] d);
    @(posedge hclk);
    haddr  <= {20'h0, idx, 2'b00};
    hwrite <= w;
    htrans <= 2'b10;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rdq = hrdata;
  endtask
  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    ahb(1'b1, idx, {24'h0, d});
  endtask
  task automatic rd_chk(input logic [9:0] idx, input logic [7:0] e);
    ahb(1'b0, idx, 32'h0);
    chk(rdq, {24'h0, e});
  endtask
  task automatic settle;
    repeat (5) @(posedge hclk);
    #1;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs;
    rd_chk(`PXB_IDX_PORT, 8'hFF);
    rd_chk(`PXB_IDX_IN_MODE, 8'hFF);
    rd_chk(`PXB_IDX_OUT_MODE, 8'h00);
    rd_chk(`PXB_IDX_ROUTE, 8'h00);
    wr(`PXB_IDX_SKIP, 8'hFF);
    rd_chk(`PXB_IDX_SKIP, 8'h7F);
    wr(`PXB_IDX_XBAR, 8'h38);
    rd_chk(`PXB_IDX_XBAR, 8'h00);
    wr(10'h3FF, 8'hAA);
    chk({31'h0, hresp}, 32'h0);
    rd_chk(10'h3FF, 8'h00);
    wr(`PXB_IDX_SKIP, 8'h00);
  endtask
  task automatic t_off;
    wr(`PXB_IDX_OUT_MODE, 8'hFF);
    wr(`PXB_IDX_ROUTE, 8'hFF);
    wr(`PXB_IDX_XBAR, 8'h07);
    settle;
    chk({24'h0, pin_oe_n}, 32'hFF);
    chk({29'h0, t1_i, t0_i, eci_i}, 32'h7);
  endtask
  task automatic t_prio;
    @(posedge hclk);
    {tx_o, sda_o, scl_o, sck_o} <= 4'b0011;
    {ext_en, ext_val} <= {8'h20, 8'h00};
    wr(`PXB_IDX_ROUTE, 8'h0F);
    wr(`PXB_IDX_XBAR, 8'h40);
    settle;
    chk({24'h0, pin_oe_n}, 32'h22);
    chk({24'h0, pin_out & 8'hDD}, 32'hCC);
    chk({24'h0, pin_pullup_en}, 32'h02);
    chk({29'h0, rx_i, sda_i, scl_i}, 32'h1);
    rd_chk(`PXB_IDX_PORT, 8'hCE);
    wr(`PXB_IDX_ROUTE, 8'h2B);
    settle;
    chk({24'h0, pin_oe_n}, 32'h20);
    chk({24'h0, pin_out & 8'hDF}, 32'hCE);
  endtask
  task automatic t_skip;
    @(posedge hclk);
    {tx_o, sda_o, scl_o, cmp_o, cm_o} <= 7'b1111000;
    ext_val <= 8'h20;
    wr(`PXB_IDX_SKIP, 8'h44);
    wr(`PXB_IDX_ROUTE, 8'h57);
    settle;
    chk({24'h0, pin_oe_n}, 32'h23);
    chk({24'h0, pin_out & 8'hDC}, 32'h5C);
    chk({24'h0, pin_pullup_en}, 32'h03);
    chk({29'h0, cm_i}, 32'h6);
    wr(`PXB_IDX_SKIP, 8'h00);
  endtask
  task automatic t_cex;
    for (int k = 0; k < 4; k++) begin
      wr(`PXB_IDX_ROUTE, {k[1:0], 6'h03});
      settle;
      chk({28'h0, pin_out[3:0]}, {28'h0, 4'hF << k});
      chk({28'h0, pin_oe_n[3:0]}, 32'h0);
    end
    @(posedge hclk);
    {ext_en, ext_val} <= {8'hE8, 8'h00};
    wr(`PXB_IDX_XBAR, 8'h47);
    settle;
    chk({24'h0, pin_oe_n}, 32'hE8);
    chk({29'h0, t1_i, t0_i, eci_i}, 32'h0);
  endtask
  task automatic t_modes;
    @(posedge hclk);
    {ext_en, ext_val} <= {8'h01, 8'h00};
    wr(`PXB_IDX_ROUTE, 8'h00);
    wr(`PXB_IDX_IN_MODE, 8'hFE);
    wr(`PXB_IDX_OUT_MODE, 8'h01);
    wr(`PXB_IDX_PORT, 8'hF0);
    wr(`PXB_IDX_XBAR, 8'h40);
    settle;
    chk({24'h0, pin_oe_n}, 32'hF1);
    chk({24'h0, pin_pullup_en}, 32'hF0);
    chk({24'h0, pin_dig_in_en}, 32'hFE);
    rd_chk(`PXB_IDX_PORT, 8'hF1);
    wr(`PXB_IDX_XBAR, 8'hC0);
    settle;
    chk({24'h0, pin_pullup_en}, 32'h00);
    rd_chk(`PXB_IDX_XBAR, 8'hC0);
  endtask

  task automatic conclude;
    if (bad_count == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  initial begin
    repeat (20000) @(posedge hclk);
    bad_count++;
    conclude;
  end
  initial begin
    {hresetn, hsel, hwrite, htrans, hsize, haddr, hwdata} = {1'b0, 1'b1, 1'b0, 2'b00, 3'h2, 64'h0};
    {ext_en, ext_val, tx_o, sda_o, scl_o, cmp_o, cmpa_o, sck_o, cm_o} = 25'h0;
    bad_count = 0;
    checks_done = 0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    settle;
    chk({24'h0, pin_dig_in_en}, 32'hFF);
    t_regs;
    t_off;
    t_prio;
    t_skip;
    t_cex;
    t_modes;
    conclude;
  end
endmodule // priority_crossbar_port_mux_tb
`default_nettype wire
